// ### pkg/rbw_pkg.sv
// package of constants and types for the reset, boot and watchdog control
package rbw_pkg;
	// boot sources after decode
	typedef enum logic [2:0] {
		RBW_BOOT_SPI_SLAVE,
		RBW_BOOT_SPI_MASTER,
		RBW_BOOT_FLASH8,
		RBW_BOOT_ROM,
		RBW_BOOT_RESERVED
	} rbw_boot_e;
	localparam logic [2:0] RBW_CFG3_SLAVE = 3'h0;
	localparam logic [2:0] RBW_CFG3_MASTER = 3'h1;
	localparam logic [2:0] RBW_CFG3_FLASH = 3'h2;
	localparam logic [2:0] RBW_CFG3_ROM = 3'h3;
	localparam logic [1:0] RBW_CFG2_SLAVE = 2'h0;
	localparam logic [1:0] RBW_CFG2_MASTER = 2'h1;
	localparam logic [1:0] RBW_CFG2_ROM = 2'h3;
	localparam int RBW_WDOG_W = 32;
	localparam logic [31:0] RBW_WDOG_RST_COUNT = 32'hffffffff;
	localparam logic [31:0] RBW_WDOG_TERMINAL = 32'h00000000;
	// length of generated reset pulses
	localparam int RBW_RST_PULSE_NS = 800;
	localparam int RBW_CLK_NS = 50;
	localparam logic [4:0] RBW_RST_PULSE_CYC =
		5'((RBW_RST_PULSE_NS + RBW_CLK_NS - 1) / RBW_CLK_NS);
endpackage

// ### core/rbw_sync.sv
// two flip-flop synchroniser for a single pin level
`timescale 1ns/100ps
`default_nettype none
module rbw_sync
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_rst_val,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_ff;
	logic sync_ff;
	logic [1:0] prime_ff;

	// first stage feeds only the second; all flops clear on reset
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	// output stays quiet until the second stage holds a real pin sample,
	// so a pin that idles high gives no false request after reset
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			prime_ff <= 2'h0;
		else
			prime_ff <= {prime_ff[0], 1'b1};
	end

	// high while the pin sits away from its idle level i_rst_val
	assign o_sync = prime_ff[1] & (sync_ff ^ i_rst_val);
endmodule
`default_nettype wire

// ### core/rbw_ctrl.sv
// reset, boot-source and watchdog control block
//
// Functional notes
// - three-pin codes 000, 001, 010 pick slave spi, master spi, flash8.
// - three-pin code 011 runs from rom and any 1xx code is reserved.
// - two-pin codes 00, 01, 11 are slave, master, rom; 10 is reserved.
// - power-up boots from 8-bit external memory or spi master/slave.
// - a running reset resets core and peripherals only, with no boot.
// - the shared reset pin, pulled low from outside, starts one.
// - the watchdog is a 32-bit down counter expiring at its terminal.
// - watchdog expiry before a reload produces a system reset.
// - the watchdog reset hits the core and all peripherals; the code holds o_pll_rst_b and o_sdram_rst_b high for it too.
// - the watchdog drives its own reset output pin on expiry.
`timescale 1ns/100ps
`default_nettype none
module rbw_ctrl
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_pkg_short,
	input wire logic [2:0] i_boot_select_pins,
	input wire logic i_reset_out_running_reset_in,
	output logic o_reset_out_running_reset_out,
	output logic o_reset_out_running_reset_oe_b,
	input wire logic i_watchdog_clock_input,
	input wire logic i_wdog_load,
	input wire logic [31:0] i_wdog_count,
	input wire logic i_wdog_enable,
	input wire logic i_wdog_reload,
	output logic [31:0] o_wdog_value,
	output logic o_watchdog_reset_output,
	output logic [2:0] o_boot_mode,
	output logic o_boot_start,
	output logic o_core_rst_b,
	output logic o_periph_rst_b,
	output logic o_pll_rst_b,
	output logic o_sdram_rst_b
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic runrst_pin_low;
	logic wdclk_s;
	logic wdclk_d_ff;
	logic wd_tick;

	// the shared pin idles high, so invert it into an active-high request
	rbw_sync u_sync_rr
	(
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_rst_val(1'b1),
		.i_async(i_reset_out_running_reset_in),
		.o_sync(runrst_pin_low)
	);

	rbw_sync u_sync_wd
	(
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_rst_val(1'b0),
		.i_async(i_watchdog_clock_input),
		.o_sync(wdclk_s)
	);

	// watchdog clock rising edge as an enable; pin must be slower than clk/2
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			wdclk_d_ff <= 1'b0;
		else
			wdclk_d_ff <= wdclk_s;
	end
	assign wd_tick = wdclk_s & ~wdclk_d_ff;

	// ************************************************************
	// boot select capture and decode
	// ************************************************************
	logic boot_taken_ff;
	rbw_pkg::rbw_boot_e mode_ff;
	rbw_pkg::rbw_boot_e nxt_mode;
	logic boot_start_ff;
	logic [3:0] strap_meta_ff;
	logic [3:0] strap_sync_ff;
	logic [1:0] strap_age_ff;

	// straps are pins too, so they pass two flops before the decoder;
	// the age bits mark when the second stage holds a real sample
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			strap_meta_ff <= 4'h0;
			strap_sync_ff <= 4'h0;
			strap_age_ff <= 2'h0;
		end
		else
		begin
			strap_meta_ff <= {i_pkg_short, i_boot_select_pins};
			strap_sync_ff <= strap_meta_ff;
			strap_age_ff <= {strap_age_ff[0], 1'b1};
		end
	end

	function automatic rbw_pkg::rbw_boot_e decode_boot(input logic s,
		input logic [2:0] p);
		rbw_pkg::rbw_boot_e m;
		m = rbw_pkg::RBW_BOOT_RESERVED;
		if (s)
		begin
			unique case (p[1:0])
				rbw_pkg::RBW_CFG2_SLAVE: m = rbw_pkg::RBW_BOOT_SPI_SLAVE;
				rbw_pkg::RBW_CFG2_MASTER: m = rbw_pkg::RBW_BOOT_SPI_MASTER;
				rbw_pkg::RBW_CFG2_ROM: m = rbw_pkg::RBW_BOOT_ROM;
				default: m = rbw_pkg::RBW_BOOT_RESERVED;
			endcase
		end
		else if (!p[2])
		begin
			unique case (p)
				rbw_pkg::RBW_CFG3_SLAVE: m = rbw_pkg::RBW_BOOT_SPI_SLAVE;
				rbw_pkg::RBW_CFG3_MASTER: m = rbw_pkg::RBW_BOOT_SPI_MASTER;
				rbw_pkg::RBW_CFG3_FLASH: m = rbw_pkg::RBW_BOOT_FLASH8;
				rbw_pkg::RBW_CFG3_ROM: m = rbw_pkg::RBW_BOOT_ROM;
				default: m = rbw_pkg::RBW_BOOT_RESERVED;
			endcase
		end
		return m;
	endfunction

	// straps are static, so one synchronised sample after release is safe
	assign nxt_mode = decode_boot(strap_sync_ff[3], strap_sync_ff[2:0]);

	// sample exactly once after power-up release, hold until next one
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			boot_taken_ff <= 1'b0;
			mode_ff <= rbw_pkg::RBW_BOOT_RESERVED;
			boot_start_ff <= 1'b0;
		end
		else
		begin
			boot_start_ff <= 1'b0;
			if (!boot_taken_ff && strap_age_ff[1])
			begin
				boot_taken_ff <= 1'b1;
				mode_ff <= nxt_mode;
				// only a power-up release loads memory from a boot source
				boot_start_ff <= (nxt_mode != rbw_pkg::RBW_BOOT_ROM) &&
					(nxt_mode != rbw_pkg::RBW_BOOT_RESERVED);
			end
		end
	end
	assign o_boot_mode = mode_ff;
	assign o_boot_start = boot_start_ff;

	// ************************************************************
	// watchdog counter
	// ************************************************************
	logic [31:0] wd_load_ff;
	logic [31:0] wd_cnt_ff;
	logic wd_en_ff;
	logic wd_expire;

	// held count value; written before enabling
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			wd_load_ff <= rbw_pkg::RBW_WDOG_RST_COUNT;
		else if (i_wdog_load)
			wd_load_ff <= i_wdog_count;
	end

	// a load or reload in the same cycle restarts the count, no expiry
	assign wd_expire = wd_en_ff && wd_tick && !i_wdog_reload &&
		!i_wdog_load &&
		(wd_cnt_ff == rbw_pkg::RBW_WDOG_TERMINAL + 32'h1);

	// reload wins over a tick; expiry clears the enable for one cycle, then it follows i_wdog_enable again
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wd_cnt_ff <= rbw_pkg::RBW_WDOG_RST_COUNT;
			wd_en_ff <= 1'b0;
		end
		else
		begin
			if (i_wdog_load)
				wd_cnt_ff <= i_wdog_count;
			else if (i_wdog_reload)
				wd_cnt_ff <= wd_load_ff;
			else if (wd_en_ff && wd_tick &&
				wd_cnt_ff != rbw_pkg::RBW_WDOG_TERMINAL)
				wd_cnt_ff <= wd_cnt_ff - 32'h1;
			if (wd_expire)
				wd_en_ff <= 1'b0;
			else
				wd_en_ff <= i_wdog_enable;
		end
	end
	assign o_wdog_value = wd_cnt_ff;

	// ************************************************************
	// reset pulse generation
	// ************************************************************
	logic [4:0] run_cnt_ff;
	logic [4:0] wd_cnt_rst_ff;
	logic run_busy;
	logic wd_busy;

	// running reset: pin request; reloads every cycle the pin is low, counts down after release
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			run_cnt_ff <= 5'h0;
		else if (runrst_pin_low)
			run_cnt_ff <= rbw_pkg::RBW_RST_PULSE_CYC;
		else if (run_cnt_ff != 5'h0)
			run_cnt_ff <= run_cnt_ff - 5'h1;
	end

	// watchdog system reset pulse
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			wd_cnt_rst_ff <= 5'h0;
		else if (wd_expire)
			wd_cnt_rst_ff <= rbw_pkg::RBW_RST_PULSE_CYC;
		else if (wd_cnt_rst_ff != 5'h0)
			wd_cnt_rst_ff <= wd_cnt_rst_ff - 5'h1;
	end

	assign run_busy = (run_cnt_ff != 5'h0);
	assign wd_busy = (wd_cnt_rst_ff != 5'h0);

	// running reset spares pll and sdram and never restarts boot
	assign o_core_rst_b = ~(run_busy | wd_busy);
	assign o_periph_rst_b = ~(run_busy | wd_busy);
	assign o_pll_rst_b = 1'b1;
	assign o_sdram_rst_b = 1'b1;
	assign o_watchdog_reset_output = wd_busy;

	// shared pin is driven low only for a watchdog reset, else released
	assign o_reset_out_running_reset_out = 1'b0;
	assign o_reset_out_running_reset_oe_b = ~wd_busy;
endmodule
`default_nettype wire

// ### bench/rbw_chk.sv
// port checker for the reset, boot and watchdog control
`timescale 1ns/100ps
`default_nettype none
module rbw_chk
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_reset_out_running_reset_in,
	input wire logic o_reset_out_running_reset_oe_b,
	input wire logic [31:0] o_wdog_value,
	input wire logic o_watchdog_reset_output,
	input wire logic [2:0] o_boot_mode,
	input wire logic o_boot_start,
	input wire logic o_core_rst_b,
	input wire logic o_periph_rst_b,
	input wire logic o_pll_rst_b,
	input wire logic o_sdram_rst_b
);
	// short names; rst means core and peripherals both held
	wire wd = o_watchdog_reset_output;
	wire pin = i_reset_out_running_reset_in;
	wire rst = !o_core_rst_b && !o_periph_rst_b;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);
	a_pll_spared: assert property (o_pll_rst_b && o_sdram_rst_b)
		else $error("pll hit");
	a_run_enter: assert property (!pin [*4] |-> rst)
		else $error("no run reset");
	a_wd_pin: assert property (wd == !o_reset_out_running_reset_oe_b)
		else $error("pin drive");
	a_wd_hits_all: assert property (wd |-> rst)
		else $error("wd reset");
	a_wd_pulse_len: assert property ($rose(wd) |-> wd [*8] ##1 wd [*8] ##1 !wd)
		else $error("wd length");
	a_wd_on_expiry: assert property (
		$past(o_wdog_value) == 32'h1 && o_wdog_value == 32'h0 |-> ##[0:1] wd)
		else $error("no expiry");
	a_boot_held: assert property (
		$past(i_rst_b) && $past(i_rst_b, 2) && $past(i_rst_b, 3) &&
		$past(i_rst_b, 4) |-> $stable(o_boot_mode))
		else $error("mode moved");
	a_boot_source: assert property (o_boot_start |-> o_boot_mode < 3'h3)
		else $error("bad boot");
	// main scenarios reached
	cover property ($rose(wd));
	cover property ($fell(o_core_rst_b) && !wd);
	cover property (o_boot_start);
endmodule
`default_nettype wire

// ### bench/rbw_partner.sv
// outside reset source, pulled-up shared pin and watchdog clock
`timescale 1ns/100ps
`default_nettype none
module rbw_partner
(
	input wire logic i_ext_pull,
	input wire logic i_dev_oe_b,
	input wire logic i_wclk_run,
	output logic o_pin,
	output logic o_wclk
);
	// pull-up wire: low when either party pulls it
	assign o_pin = !i_ext_pull && i_dev_oe_b;
	// slow tick clock, far under the sync limit; parked low when unused
	initial
	begin
		o_wclk = 1'h0;
		forever
			#400 o_wclk = i_wclk_run && !o_wclk;
	end
endmodule
`default_nettype wire

// ### bench/test_reset_boot_watchdog_control.sv
// self-checking bench for the reset, boot and watchdog control
`timescale 1ns/100ps
`default_nettype none
module test_reset_boot_watchdog_control;
	logic i_core_clk = 1'h0, i_rst_b = 1'h0, i_pkg_short = 1'h0;
	logic i_wdog_load = 1'h0, i_wdog_enable = 1'h0, i_wdog_reload = 1'h0;
	logic pull = 1'h0, run = 1'h0;
	logic [2:0] i_boot_select_pins = 3'h0, o_boot_mode;
	logic [31:0] i_wdog_count = 32'h0, o_wdog_value;
	logic i_reset_out_running_reset_in, i_watchdog_clock_input;
	logic o_reset_out_running_reset_out, o_reset_out_running_reset_oe_b;
	logic o_watchdog_reset_output, o_boot_start, o_core_rst_b;
	logic o_periph_rst_b, o_pll_rst_b, o_sdram_rst_b;
	int fail_count = 0, checks_done = 0, cyc = 0;
	rbw_ctrl DUT
	(
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_pkg_short(i_pkg_short),
		.i_boot_select_pins(i_boot_select_pins),
		.i_reset_out_running_reset_in(i_reset_out_running_reset_in),
		.o_reset_out_running_reset_out(o_reset_out_running_reset_out),
		.o_reset_out_running_reset_oe_b(o_reset_out_running_reset_oe_b),
		.i_watchdog_clock_input(i_watchdog_clock_input),
		.i_wdog_load(i_wdog_load),
		.i_wdog_count(i_wdog_count),
		.i_wdog_enable(i_wdog_enable),
		.i_wdog_reload(i_wdog_reload),
		.o_wdog_value(o_wdog_value),
		.o_watchdog_reset_output(o_watchdog_reset_output),
		.o_boot_mode(o_boot_mode),
		.o_boot_start(o_boot_start),
		.o_core_rst_b(o_core_rst_b),
		.o_periph_rst_b(o_periph_rst_b),
		.o_pll_rst_b(o_pll_rst_b),
		.o_sdram_rst_b(o_sdram_rst_b)
	);
	rbw_partner PM (.i_ext_pull(pull), .i_wclk_run(run),
		.i_dev_oe_b(o_reset_out_running_reset_oe_b),
		.o_pin(i_reset_out_running_reset_in),
		.o_wclk(i_watchdog_clock_input));
	// 50 ns clock
	initial
		forever
			#25 i_core_clk = !i_core_clk;
	// hang guard, far above the few hundred cycles used
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end
	task cy(int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// outputs are looked at mid-cycle, where they have settled
	task mid();
		@(negedge i_core_clk);
	endtask
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task finish_test();
		$display("mismatches %0d checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// power-up with given straps; later strap moves must not count
	task boot(logic s, logic [2:0] p, logic [2:0] m);
		cy(1);
		i_pkg_short <= s;
		i_boot_select_pins <= p;
		i_rst_b <= 1'h0;
		cy(2);
		i_rst_b <= 1'h1;
		// straps pass two sync flops, so capture lands on the third edge
		cy(2);
		mid();
		chk("early", o_boot_start, 1'h0);
		cy(1);
		mid();
		chk("mode", o_boot_mode, m);
		chk("start", o_boot_start, m < 3'h3);
		cy(1);
		i_boot_select_pins <= ~p;
		cy(4);
		mid();
		chk("held", o_boot_mode, m);
		chk("once", o_boot_start, 1'h0);
	endtask
	// outside party pulls the shared pin low, then lets it go
	task t_run();
		cy(1);
		pull <= 1'h1;
		cy(2);
		mid();
		chk("run early", o_core_rst_b, 1'h1);
		cy(1);
		mid();
		chk("run", {o_core_rst_b, o_periph_rst_b}, 2'h0);
		chk("pll", {o_pll_rst_b, o_sdram_rst_b}, 2'h3);
		cy(3);
		pull <= 1'h0;
		// two sync edges, the second also the last reload, then the full pulse count
		cy(17);
		mid();
		chk("run hold", o_periph_rst_b, 1'h0);
		cy(1);
		mid();
		chk("run end", {o_core_rst_b, o_boot_start, o_boot_mode},
			5'h13);
	endtask
	task t_wdog();
		logic [31:0] v;
		cy(1);
		i_wdog_count <= 32'h3;
		i_wdog_load <= 1'h1;
		run <= 1'h1;
		cy(1);
		i_wdog_load <= 1'h0;
		cy(40);
		mid();
		chk("idle", o_wdog_value, 32'h3);
		cy(1);
		i_wdog_enable <= 1'h1;
		// look mid-cycle until the expiry pulse shows, bounded
		for (int i = 0; i < 80 && o_watchdog_reset_output !== 1'h1; i++)
			mid();
		chk("expiry", o_wdog_value, 32'h0);
		chk("wd", {o_watchdog_reset_output, o_reset_out_running_reset_oe_b,
			o_reset_out_running_reset_out, o_core_rst_b,
			o_periph_rst_b}, 5'h10);
		cy(1);
		i_wdog_enable <= 1'h0;
		// own pin drive adds a running reset that outlasts the pulse
		cy(32);
		mid();
		chk("wd hold", {o_watchdog_reset_output, o_core_rst_b}, 2'h0);
		cy(1);
		mid();
		chk("after", {o_watchdog_reset_output, o_core_rst_b}, 2'h1);
		cy(1);
		i_wdog_count <= 32'h40;
		i_wdog_load <= 1'h1;
		cy(1);
		i_wdog_load <= 1'h0;
		i_wdog_enable <= 1'h1;
		cy(60);
		run <= 1'h0;
		cy(20);
		mid();
		// at most four watchdog clock rises fit in the counting window
		chk("count", {o_wdog_value < 32'h40, o_wdog_value > 32'h3b},
			2'h3);
		v = o_wdog_value;
		// a parked watchdog clock must freeze the count
		cy(20);
		mid();
		chk("parked", o_wdog_value, v);
		cy(1);
		i_wdog_reload <= 1'h1;
		cy(1);
		i_wdog_reload <= 1'h0;
		cy(1);
		mid();
		chk("reload", o_wdog_value, 32'h40);
	endtask
	initial
	begin
		for (int k = 0; k < 8; k++)
			boot(1'h0, 3'(k), k < 4 ? 3'(k) : 3'h4);
		for (int k = 0; k < 4; k++)
			boot(1'h1, 3'(k), k == 2 ? 3'h4 : 3'(k));
		t_run();
		t_wdog();
		finish_test();
	end
endmodule
bind rbw_ctrl rbw_chk CHK
(
	.i_core_clk(i_core_clk),
	.i_rst_b(i_rst_b),
	.i_reset_out_running_reset_in(i_reset_out_running_reset_in),
	.o_reset_out_running_reset_oe_b(o_reset_out_running_reset_oe_b),
	.o_wdog_value(o_wdog_value),
	.o_watchdog_reset_output(o_watchdog_reset_output),
	.o_boot_mode(o_boot_mode),
	.o_boot_start(o_boot_start),
	.o_core_rst_b(o_core_rst_b),
	.o_periph_rst_b(o_periph_rst_b),
	.o_pll_rst_b(o_pll_rst_b),
	.o_sdram_rst_b(o_sdram_rst_b)
);
`default_nettype wire
